//--- rf_block_params.svh
// constants of the rf single block read/write interpreter
`ifndef RF_BLOCK_PARAMS_SVH
`define RF_BLOCK_PARAMS_SVH

`define RF_CLK_NS 10
`define RF_T1_NS 320900
`define RF_WT_PERIOD_NS 302000
`define RF_WT_PERIODS 18

`define RF_CMD_READ 8'h20
`define RF_CMD_WRITE 8'h21

`define RF_FLAG_PROTEXT 3
`define RF_FLAG_ADDR 5
`define RF_FLAG_OPTION 6

`define RF_RSP_OK 8'h00
`define RF_RSP_ERR 8'h01
`define RF_ERR_UNSPEC 8'h0F
`define RF_ERR_NOBLOCK 8'h10
`define RF_ERR_LOCKED 8'h12
`define RF_ERR_PROGFAIL 8'h13
`define RF_ERR_RDPROT 8'h15

`define RF_CRC_INIT 16'hFFFF
`define RF_CRC_POLY 16'h8408
`define RF_CRC_GOOD 16'hF0B8

`define RF_HDR_LEN 5'h02
`define RF_UID_LEN 5'h08
`define RF_BLK_LEN 5'h02
`define RF_DATA_LEN 5'h04
`define RF_CRC_LEN 5'h02
`define RF_CNT_MAX 5'h1F

`define RF_SEC_LOCK 0
`define RF_SEC_RDPROT 1
`define RF_SEC_WRPROT 2
`define RF_SEC_PWD_LSB 3
`define RF_SEC_SHIFT 4

`define RF_REG_CTRL 8'h00
`define RF_REG_STATUS 8'h04
`define RF_REG_SECT 8'h08
`define RF_CTRL_BUSY 0
`define RF_CTRL_EN 1
`define RF_SECT_IDX_LSB 8

`endif

//--- rf_block_pkg.sv
// types shared by the rf block interpreter files
package rf_block_pkg;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_RECV   = 8'h02,
    ST_CHECK  = 8'h04,
    ST_DECIDE = 8'h08,
    ST_WRITE  = 8'h10,
    ST_WAITEOF = 8'h20,
    ST_T1     = 8'h40,
    ST_TX     = 8'h80
  } state_t;

  typedef logic [4:0] sec_status_t;

endpackage

//--- blk_mem_if.sv
// port bundle between the interpreter and its block store
`timescale 1ns/10ps
interface blk_mem_if #(parameter int AW = 9, parameter int DW = 32);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic we;
  logic [DW-1:0] rdata;

  modport user (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface

//--- blk_mem.sv
// single port block store with registered read data
`timescale 1ns/10ps
module blk_mem #(
  parameter int AW = 9,
  parameter int DW = 32
)(
  input wire logic clk_i,
  blk_mem_if.store port
);
  logic [DW-1:0] cells [0:(1<<AW)-1];
  logic [DW-1:0] rdata;

  // write the addressed word; read data is the word held before that write
  always_ff @(posedge clk_i)
  begin
    if (port.we)
    begin
      cells[port.addr] <= port.wdata;
    end
    rdata <= cells[port.addr];
  end

  assign port.rdata = rdata;
endmodule

//--- rf_crc16.sv
// byte-wise crc16 for rf frames, reflected polynomial
`timescale 1ns/10ps
`include "rf_block_params.svh"
module rf_crc16 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic valid_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] crc_o
);
  typedef struct packed {
    logic [15:0] crc;
  } crc_state_t;

  crc_state_t q;
  crc_state_t next_q;

  // fold one byte into the running value
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `RF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // init wins over a byte in the same cycle
  always_comb
  begin
    next_q = q;
    if (init_i)
      next_q.crc = `RF_CRC_INIT;
    else if (valid_i)
      next_q.crc = crc_step(q.crc, byte_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '{crc: `RF_CRC_INIT};
    else
      q <= next_q;
  end

  assign crc_o = q.crc;
endmodule

//--- rf_block_cmd.sv
// rf read-one-block / write-one-block command interpreter with wishbone control
//
// How it works
// - valid read returns whole 32-bit block
// - extension flag clear answers error, no action
// - read request: flags, 20h, uid, block, crc
// - read reply: flags, optional security, data, crc
// - security byte: lock, protect, password, zeros
// - read errors: 10h missing, 15h protected
// - busy mode: pin low sof to reply end
// - progress mode: pin released during reads
// - valid write programs block, reports outcome
// - write request: flags, 21h, uid, block, data, crc
// - write reply flags+crc after write cycle
// - write errors: 0Fh, 10h, 12h, 13h
// - busy mode: pin low through write exchange
// - progress mode: pin low during write cycle; option write keeps it low to reply end
// - forbidden write: no cycle, pin released in progress mode
// - option write: reply t1 after extra eof
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "rf_block_params.svh"
module rf_block_cmd #(
  parameter int NUM_BLOCKS = 512,
  parameter int AW = 9,
  parameter int SECTORS = 32,
  parameter logic [63:0] UID = 64'h0123_4567_89AB_CDEF, // arbitrary value
  parameter int unsigned T1_CYCLES = (`RF_T1_NS + `RF_CLK_NS - 1) / `RF_CLK_NS,
  parameter int unsigned WT_CYCLES = (`RF_T1_NS + `RF_WT_PERIODS * `RF_WT_PERIOD_NS + `RF_CLK_NS - 1) / `RF_CLK_NS
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_eof_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic prog_fail_i,
  output logic rf_activity_out_o,
  output logic rf_activity_out_oe_o,
  output logic rf_write_pending_out_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import rf_block_pkg::*;

  localparam int TW = 24;

  typedef struct packed {
    state_t st;
    logic [4:0] cnt;
    logic [7:0] flags;
    logic [7:0] cmd;
    logic [15:0] blk;
    logic [31:0] wdata;
    logic uid_ok;
    logic [TW-1:0] timer;
    logic [5:0][7:0] rsp;
    logic [2:0] rlen;
    logic [3:0] ti;
    logic act;
    logic [7:0] last_err;
    logic busy_mode;
    logic enable;
    logic [SECTORS-1:0][4:0] sect;
    logic ack;
    logic [31:0] dat;
  } cmd_state_t;

  cmd_state_t q;
  cmd_state_t next_q;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic tx_take;
  logic tx_payload;
  logic [4:0] hdr;
  logic [4:0] pos;
  logic [4:0] exp_len;
  logic is_write;
  sec_status_t sec;
  logic wb_hit;

  blk_mem_if #(.AW(AW), .DW(32)) mem ();

  blk_mem #(.AW(AW), .DW(32)) store_u (
    .clk_i(clk_i),
    .port(mem.store)
  );

  // receive crc runs over every frame byte
  rf_crc16 rx_crc_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(rx_sof_i),
    .valid_i(rx_valid_i),
    .byte_i(rx_byte_i),
    .crc_o(rx_crc)
  );

  // transmit crc runs over the reply payload
  rf_crc16 tx_crc_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(q.st != ST_TX),
    .valid_i(tx_take && tx_payload),
    .byte_i(tx_byte_o),
    .crc_o(tx_crc)
  );

  // error reply builder
  function automatic logic [5:0][7:0] err_rsp(input logic [7:0] code);
    logic [5:0][7:0] r;
    r = '0;
    r[0] = `RF_RSP_ERR;
    r[1] = code;
    return r;
  endfunction

  // field positions inside the request
  always_comb
  begin
    hdr = q.flags[`RF_FLAG_ADDR] ? (`RF_HDR_LEN + `RF_UID_LEN) : `RF_HDR_LEN;
    pos = q.cnt - hdr;
    is_write = (q.cmd == `RF_CMD_WRITE);
    exp_len = hdr + `RF_BLK_LEN + (is_write ? `RF_DATA_LEN : 5'h00) + `RF_CRC_LEN;
    sec = q.sect[q.blk[`RF_SEC_SHIFT +: 5]];
    wb_hit = wb_cyc_i && wb_stb_i && !q.ack;
  end

  // reply stream handshake
  always_comb
  begin
    tx_valid_o = (q.st == ST_TX);
    tx_payload = ({1'b0, q.ti} < {2'b00, q.rlen});
    tx_last_o = tx_valid_o && (q.ti == ({1'b0, q.rlen} + 4'h1));
    tx_take = tx_valid_o && tx_ready_i;
    if (tx_payload)
      tx_byte_o = q.rsp[q.ti[2:0]];
    else if (tx_last_o)
      tx_byte_o = ~tx_crc[15:8];
    else
      tx_byte_o = ~tx_crc[7:0];
  end

  // block store port
  always_comb
  begin
    mem.addr = q.blk[AW-1:0];
    mem.wdata = q.wdata;
    mem.we = (q.st == ST_DECIDE) && is_write && (q.blk < 16'(NUM_BLOCKS))
             && !sec[`RF_SEC_LOCK] && !sec[`RF_SEC_WRPROT];
  end

  // next state of the interpreter and the control registers
  always_comb
  begin
    next_q = q;
    next_q.ack = wb_hit;
    if (wb_hit)
    begin
      case (wb_adr_i)
        `RF_REG_CTRL: next_q.dat = {30'h0, q.enable, q.busy_mode};
        `RF_REG_STATUS: next_q.dat = {16'h0, q.last_err, q.st};
        default: next_q.dat = 32'h0;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == `RF_REG_CTRL)
      begin
        next_q.busy_mode = wb_dat_i[`RF_CTRL_BUSY];
        next_q.enable = wb_dat_i[`RF_CTRL_EN];
      end
      else if (wb_adr_i == `RF_REG_SECT)
      begin
        next_q.sect[wb_dat_i[`RF_SECT_IDX_LSB +: 5]] = wb_dat_i[4:0];
      end
    end
    case (q.st)
      ST_IDLE:
      begin
        if (rx_sof_i && q.enable)
        begin
          next_q.st = ST_RECV;
          next_q.cnt = 5'h00;
          next_q.uid_ok = 1'b1;
          next_q.act = q.busy_mode;
        end
      end
      ST_RECV:
      begin
        if (rx_valid_i)
        begin
          if (q.cnt != `RF_CNT_MAX)
            next_q.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'h00)
            next_q.flags = rx_byte_i;
          else if (q.cnt == 5'h01)
            next_q.cmd = rx_byte_i;
          else if (q.cnt < hdr)
            next_q.uid_ok = q.uid_ok && (rx_byte_i == UID[8 * (q.cnt - `RF_HDR_LEN) +: 8]);
          else if (pos < `RF_BLK_LEN)
            next_q.blk[8 * pos[0] +: 8] = rx_byte_i;
          else if (pos < `RF_BLK_LEN + `RF_DATA_LEN)
            next_q.wdata[8 * 2'(pos[1:0] - 2'h2) +: 8] = rx_byte_i; // wrap inside two bits
        end
        else if (rx_eof_i)
        begin
          next_q.st = ST_IDLE;
          next_q.act = 1'b0;
          if (rx_crc != `RF_CRC_GOOD || !q.uid_ok
              || (q.cmd != `RF_CMD_READ && !is_write))
          begin
            next_q.st = ST_IDLE;
          end
          else if (!q.flags[`RF_FLAG_PROTEXT] || q.cnt != exp_len)
          begin
            next_q.rsp = err_rsp(`RF_ERR_UNSPEC);
            next_q.rlen = 3'h2;
            next_q.last_err = `RF_ERR_UNSPEC;
            next_q.timer = TW'(T1_CYCLES);
            next_q.st = ST_T1;
            next_q.act = q.act;
          end
          else
          begin
            next_q.st = ST_CHECK;
            next_q.act = q.act;
          end
        end
      end
      ST_CHECK:
      begin
        next_q.st = ST_DECIDE;
      end
      ST_DECIDE:
      begin
        next_q.timer = TW'(T1_CYCLES);
        next_q.st = ST_T1;
        if (q.blk >= 16'(NUM_BLOCKS))
        begin
          next_q.rsp = err_rsp(`RF_ERR_NOBLOCK);
          next_q.rlen = 3'h2;
          next_q.last_err = `RF_ERR_NOBLOCK;
        end
        else if (!is_write)
        begin
          if (sec[`RF_SEC_RDPROT])
          begin
            next_q.rsp = err_rsp(`RF_ERR_RDPROT);
            next_q.rlen = 3'h2;
            next_q.last_err = `RF_ERR_RDPROT;
          end
          else if (q.flags[`RF_FLAG_OPTION])
          begin
            next_q.rsp = {mem.rdata, 3'h0, sec, `RF_RSP_OK};
            next_q.rlen = 3'h6;
          end
          else
          begin
            next_q.rsp = {8'h00, mem.rdata, `RF_RSP_OK};
            next_q.rlen = 3'h5;
          end
        end
        else if (sec[`RF_SEC_LOCK] || sec[`RF_SEC_WRPROT])
        begin
          next_q.rsp = err_rsp(`RF_ERR_LOCKED);
          next_q.rlen = 3'h2;
          next_q.last_err = `RF_ERR_LOCKED;
        end
        else
        begin
          next_q.act = 1'b1;
          next_q.timer = TW'(WT_CYCLES);
          next_q.st = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        next_q.timer = q.timer - TW'(1);
        if (q.timer == TW'(1))
        begin
          if (prog_fail_i)
          begin
            next_q.rsp = err_rsp(`RF_ERR_PROGFAIL);
            next_q.rlen = 3'h2;
            next_q.last_err = `RF_ERR_PROGFAIL;
          end
          else
          begin
            next_q.rsp = {40'h0, `RF_RSP_OK};
            next_q.rlen = 3'h1;
          end
          if (q.flags[`RF_FLAG_OPTION])
            next_q.st = ST_WAITEOF;
          else
          begin
            next_q.st = ST_TX;
            next_q.ti = 4'h0;
            next_q.act = q.busy_mode;
          end
        end
      end
      ST_WAITEOF:
      begin
        if (rx_eof_i)
        begin
          next_q.timer = TW'(T1_CYCLES);
          next_q.st = ST_T1;
        end
      end
      ST_T1:
      begin
        next_q.timer = q.timer - TW'(1);
        if (q.timer == TW'(1))
        begin
          next_q.st = ST_TX;
          next_q.ti = 4'h0;
        end
      end
      ST_TX:
      begin
        if (tx_take)
        begin
          next_q.ti = q.ti + 4'h1;
          if (tx_last_o)
          begin
            next_q.st = ST_IDLE;
            next_q.act = 1'b0;
          end
        end
      end
      default:
      begin
        next_q.st = ST_IDLE;
        next_q.act = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.busy_mode <= 1'b1;
      q.enable <= 1'b1;
      q.uid_ok <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  // pin only ever pulls low; released means high impedance
  assign rf_activity_out_o = 1'b0;
  assign rf_activity_out_oe_o = q.act;
  assign rf_write_pending_out_o = (q.st == ST_WRITE);
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
endmodule

//--- rf_block_cmd_assertions.sv
// port checker for the rf block interpreter
`timescale 1ns/10ps
module rf_block_cmd_assertions #(
  parameter int unsigned T1_CYCLES = 20
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_eof_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic rf_activity_out_o,
  input wire logic rf_activity_out_oe_o,
  input wire logic rf_write_pending_out_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  int unsigned gap;
  // cycles since the last request eof
  always_ff @(posedge clk_i)
  begin
    if (rst_i || rx_eof_i)
      gap <= 0;
    else if (gap < 32'hFFFF)
      gap <= gap + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus handshake
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
  // reply stream, write cycle and pin, then covers
  a_tx_hold: assert property ((tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte changed while stalled");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o) else $error("last without valid");
  a_write_silent: assert property (rf_write_pending_out_o |-> !tx_valid_o)
    else $error("reply during write cycle");
  a_write_pin: assert property (rf_write_pending_out_o |-> rf_activity_out_oe_o)
    else $error("pin released during write cycle");
  a_write_span: assert property ($rose(rf_write_pending_out_o) |-> rf_write_pending_out_o [*8])
    else $error("write cycle too short");
  a_reply_gap: assert property ($rose(tx_valid_o) |-> gap >= T1_CYCLES - 1)
    else $error("reply too soon after eof");
  a_pin_low: assert property (rf_activity_out_oe_o |-> !rf_activity_out_o)
    else $error("driven pin not low");
  c_reply: cover property (tx_last_o && tx_ready_i);
  c_write: cover property ($rose(rf_write_pending_out_o));
  c_bus: cover property (wb_ack_o);
endmodule
bind rf_block_cmd rf_block_cmd_assertions #(.T1_CYCLES(T1_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .rx_eof_i(rx_eof_i), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o),
  .tx_ready_i(tx_ready_i), .rf_activity_out_o(rf_activity_out_o), .rf_activity_out_oe_o(rf_activity_out_oe_o),
  .rf_write_pending_out_o(rf_write_pending_out_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

//--- rf_reader_model.sv
// reader side model: frames requests, collects replies
`timescale 1ns/10ps
module rf_reader_model (
  input wire logic clk_i,
  output logic rx_sof_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_eof_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic [7:0] rsp[$];
  logic done;
  logic [1:0] pace;
  // idle lines
  initial
  begin
    {rx_sof_o, rx_valid_o, rx_eof_o, tx_ready_o, done} = 5'h00;
    rx_byte_o = 8'h00;
    pace = 2'h0;
  end
  // crc, reflected poly, init all ones
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i])
    begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return c;
  endfunction
  // sof, bytes, inverted crc, eof; bad spoils the crc
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = ~crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    rsp.delete();
    done = 1'b0;
    @(posedge clk_i);
    rx_sof_o <= 1'b1;
    foreach (f[i])
    begin
      @(posedge clk_i);
      rx_sof_o <= 1'b0;
      rx_valid_o <= 1'b1;
      rx_byte_o <= f[i];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o;
    @(posedge clk_i);
    rx_eof_o <= 1'b1;
    @(posedge clk_i);
    rx_eof_o <= 1'b0;
  endtask
  // lone eof after an option write; silent until then
  task automatic eof_only;
    @(posedge clk_i);
    rx_eof_o <= 1'b1;
    @(posedge clk_i);
    rx_eof_o <= 1'b0;
  endtask
  // take reply bytes, stalling one cycle in four
  always @(posedge clk_i)
  begin
    pace <= pace + 2'h1;
    tx_ready_o <= (pace != 2'h3);
    if (tx_valid_i && tx_ready_o)
    begin
      rsp.push_back(tx_byte_i);
      if (tx_last_i)
        done <= 1'b1;
    end
  end
endmodule

//--- rf_block_cmd_tb.sv
// self-checking bench for the rf block interpreter
`timescale 1ns/10ps
`include "rf_block_params.svh"
module rf_block_cmd_tb;
  typedef logic [7:0] bytes_t[$];
  logic clk_i, rst_i, rx_sof_i, rx_valid_i, rx_eof_i, tx_ready_i, prog_fail_i, tx_valid_o, tx_last_o;
  logic oe, pin, wip, seen, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] rx_byte_i, tx_byte_o, wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, d;
  logic [15:0] blk;
  int failures, cmp_count, seed;
  localparam logic [63:0] DUT_UID = 64'hFEDC_BA98_7654_3210; // arbitrary value
  bytes_t f;
  rf_block_cmd #(.T1_CYCLES(20), .WT_CYCLES(60), .UID(DUT_UID)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .rx_sof_i(rx_sof_i),
    .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_eof_i(rx_eof_i), .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .prog_fail_i(prog_fail_i),
    .rf_activity_out_o(pin), .rf_activity_out_oe_o(oe), .rf_write_pending_out_o(wip), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  rf_reader_model u_rdr (.clk_i(clk_i), .rx_sof_o(rx_sof_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
    .rx_eof_o(rx_eof_i), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .tx_last_i(tx_last_o),
    .tx_ready_o(tx_ready_i));
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // remembers any drive of the pin
  always @(posedge clk_i)
    if (oe === 1'b1)
      seen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits for a reply, compares bytes and crc residue
  task automatic chk_rsp(input logic [7:0] x[$]);
    int n;
    n = 0;
    while (u_rdr.done !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (u_rdr.done !== 1'b1)
      failures++;
    chk(32'(u_rdr.rsp.size()), 32'(x.size() + 2));
    foreach (x[i])
      chk({24'h000000, u_rdr.rsp[i]}, {24'h000000, x[i]});
    chk({16'h0000, u_rdr.crc16(u_rdr.rsp)}, 32'h0000F0B8);
    @(posedge clk_i);
  endtask
  // classic single wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, v, 4'hF};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      failures++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  function automatic bytes_t req(input logic [7:0] fl, input logic [7:0] cmd, input logic [15:0] b,
    input logic [31:0] v);
    bytes_t r;
    r = {fl, cmd, b[7:0], b[15:8]};
    if (cmd == `RF_CMD_WRITE)
      r = {r, v[7:0], v[15:8], v[23:16], v[31:24]};
    return r;
  endfunction
  function automatic bytes_t exp_rd(input logic opt, input logic [7:0] sec, input logic [31:0] v);
    bytes_t r;
    r = {8'h00};
    if (opt)
      r.push_back(sec);
    return {r, v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  task automatic conclude;
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (40000) @(posedge clk_i);
    failures++;
    conclude();
  end
  // main sequence
  initial
  begin
    seed = 33;
    {rst_i, prog_fail_i, wb_cyc_i, wb_stb_i, wb_we_i, seen} = 6'b100000;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `RF_REG_CTRL, 32'h0);
    chk(rd, 32'h00000003);
    wb(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h00000000);
    for (int i = 0; i < 4; i++)
    begin
      blk = 16'($random(seed)) & 16'h01EF;
      d = $random(seed);
      u_rdr.send(req(8'h08, `RF_CMD_WRITE, blk, d), 1'b0);
      chk_rsp({`RF_RSP_OK});
      u_rdr.send(req(i[0] ? 8'h48 : 8'h08, `RF_CMD_READ, blk, 0), 1'b0);
      chk_rsp(exp_rd(i[0], 8'h00, d));
    end
    u_rdr.send(req(8'h08, `RF_CMD_WRITE, 16'h0010, d), 1'b0);
    chk_rsp({`RF_RSP_OK});
    wb(1'b1, `RF_REG_SECT, 32'h00000101);
    u_rdr.send(req(8'h08, `RF_CMD_WRITE, 16'h0010, ~d), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_LOCKED});
    u_rdr.send(req(8'h48, `RF_CMD_READ, 16'h0010, 0), 1'b0);
    chk_rsp(exp_rd(1'b1, 8'h01, d));
    wb(1'b1, `RF_REG_SECT, 32'h00000102);
    u_rdr.send(req(8'h08, `RF_CMD_READ, 16'h0010, 0), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_RDPROT});
    u_rdr.send(req(8'h08, `RF_CMD_READ, 16'h0200, 0), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_NOBLOCK});
    u_rdr.send(req(8'h08, `RF_CMD_WRITE, 16'h0200, d), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_NOBLOCK});
    u_rdr.send(req(8'h00, `RF_CMD_READ, 16'h0000, 0), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_UNSPEC});
    wb(1'b0, `RF_REG_STATUS, 32'h0);
    chk(rd, {16'h0000, `RF_ERR_UNSPEC, 8'h01});
    u_rdr.send(req(8'h08, `RF_CMD_READ, 16'h0000, 0), 1'b1);
    repeat (60) @(posedge clk_i);
    chk(32'(u_rdr.rsp.size()), 32'h0);
    prog_fail_i <= 1'b1;
    u_rdr.send(req(8'h08, `RF_CMD_WRITE, 16'h0000, d), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_PROGFAIL});
    prog_fail_i <= 1'b0;
    wb(1'b1, `RF_REG_CTRL, 32'h00000002);
    seen = 1'b0;
    u_rdr.send(req(8'h08, `RF_CMD_WRITE, 16'h0000, d), 1'b0);
    chk_rsp({`RF_RSP_OK});
    chk({31'h0, seen}, 32'h1);
    seen = 1'b0;
    u_rdr.send(req(8'h08, `RF_CMD_READ, 16'h0000, 0), 1'b0);
    chk_rsp(exp_rd(1'b0, 8'h00, d));
    chk({31'h0, seen}, 32'h0);
    wb(1'b1, `RF_REG_SECT, 32'h00000104);
    seen = 1'b0;
    u_rdr.send(req(8'h08, `RF_CMD_WRITE, 16'h0010, d), 1'b0);
    chk_rsp({`RF_RSP_ERR, `RF_ERR_LOCKED});
    chk({31'h0, seen}, 32'h0);
    seen = 1'b0;
    u_rdr.send(req(8'h48, `RF_CMD_WRITE, 16'h0001, d), 1'b0);
    repeat (10) @(posedge clk_i);
    chk({31'h0, wip}, 32'h1);
    repeat (90) @(posedge clk_i);
    chk(32'(u_rdr.rsp.size()), 32'h0);
    u_rdr.eof_only();
    chk_rsp({`RF_RSP_OK});
    chk({30'h0, seen, oe}, 32'h2);
    wb(1'b1, `RF_REG_CTRL, 32'h00000003);
    seen = 1'b0;
    u_rdr.send(req(8'h08, `RF_CMD_READ, 16'h0000, 0), 1'b0);
    chk_rsp(exp_rd(1'b0, 8'h00, d));
    chk({29'h0, seen, oe, pin}, 32'h4);
    // addressed read: own identifier answered, any other ignored
    f = req(8'h28, `RF_CMD_READ, 16'h0000, 0);
    for (int k = 7; k >= 0; k--)
      f.insert(2, DUT_UID[8 * k +: 8]);
    u_rdr.send(f, 1'b0);
    chk_rsp(exp_rd(1'b0, 8'h00, d));
    f[2] = ~f[2];
    u_rdr.send(f, 1'b0);
    repeat (60) @(posedge clk_i);
    chk(32'(u_rdr.rsp.size()), 32'h0);
    conclude();
  end
endmodule
